// ==== rtl/srf_pkg.sv ====
package srf_pkg;

    // Operation select
    typedef enum logic [2:0] {
        SRF_OP_NONE       = 3'h0,
        SRF_OP_ROT_RIGHT     = 3'h1,
        SRF_OP_SHIFT_LEFT    = 3'h2,
        SRF_OP_SHIFT_LEFT_A  = 3'h3,
        SRF_OP_SHIFT_RIGHT_A = 3'h4,
        SRF_OP_FLAGS_LOAD    = 3'h5
    } srf_op_t;

    // Sequencer states, Gray coded along idle -> step -> done
    typedef enum logic [1:0] {
        SRF_ST_IDLE = 2'b00,
        SRF_ST_STEP = 2'b01,
        SRF_ST_DONE = 2'b11
    } srf_state_t;

    // Flag bundle
    typedef struct packed {
        logic overflow_flag;
        logic direction_flag;
        logic int_enable_flag;
        logic trap_flag;
        logic sign_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic parity_flag;
        logic carry_flag;
    } srf_flags_t;

    // Operation request bundle
    typedef struct packed {
        srf_op_t     op;
        logic        word_size;
        logic        count_from_reg;
        logic [7:0]  imm_count;
        logic [15:0] dest;
    } srf_req_t;

    // Positions of flag bits inside the high accumulator byte
    localparam int SRF_HAB_SIGN_BIT   = 7;
    localparam int SRF_HAB_ZERO_BIT   = 6;
    localparam int SRF_HAB_AUX_BIT    = 4;
    localparam int SRF_HAB_PARITY_BIT = 2;
    localparam int SRF_HAB_CARRY_BIT  = 0;

    // Reset values
    localparam logic [15:0] SRF_RESULT_RST = 16'h0000;
    localparam logic [8:0]  SRF_FLAGS_RST  = 9'h000;
    localparam logic [7:0]  SRF_COUNT_RST  = 8'h00;

endpackage

// ==== rtl/srf_shift_rotate_flag_unit.sv ====
`timescale 1ns/10ps
// What this block does
// RQ1 - Rotate-right turns the byte or word right one place per step, the bottom bit wrapping to the top.
// RQ2 - Each rotate-right step copies the lowest bit into carry and that bit becomes the new top bit.
// RQ3 - A rotate-right of count one sets overflow when the top two result bits differ, else clears it.
// RQ4 - The count comes from an immediate or from the count register; the destination is any operand value.
// RQ5 - Single steps repeat while the remaining count is nonzero, counting down; count zero does no step.
// RQ6 - Flag-load copies high accumulator byte bits 7, 6, 4, 2 and 0 into sign, zero, aux, parity and carry.
// RQ7 - Flag-load leaves overflow, direction, interrupt-enable and trap untouched.
// RQ8 - Logical and arithmetic left shift are one operation that shifts left and inserts zeros.
// RQ9 - Each left-shift step moves the top bit into carry before doubling the value.
// RQ10 - A left shift of count one clears overflow if the sign bit kept its value, else sets it.
// RQ11 - Arithmetic right shift moves right and fills the top with copies of the original sign.
// RQ12 - Each arithmetic-right step puts the lowest bit into carry.
// RQ13 - Arithmetic right shift rounds toward minus infinity for negatives, unlike signed division.
// RQ14 - Arithmetic right shift leaves overflow cleared.
// RQ15 - Flags an operation does not touch keep their value; undefined flags get a fixed, deterministic value.
module srf_shift_rotate_flag_unit #(
    parameter int COUNT_W = 8
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    // Request
    input  wire logic                 start,
    input  wire srf_pkg::srf_req_t    req,
    input  wire logic [COUNT_W-1:0]   count_register_low,
    input  wire logic [7:0]           high_accumulator_byte,
    // Flag load from the core and flag state out
    input  wire logic                 flags_wr,
    input  wire srf_pkg::srf_flags_t  flags_wr_data,
    output srf_pkg::srf_flags_t       flags,
    // Result
    output logic                      busy,
    output logic                      done,
    output logic [15:0]               result
);

    // Timing: a request is taken on an idle edge and that same edge enters the step phase
    // Each further edge takes one step while count remains
    // The edge after the last step writes the final flags and raises done
    // Done lasts one cycle, then the sequencer is idle again
    // Result and flags stand until the next request or core write

    // Sequencer state and captured operation
    srf_pkg::srf_state_t  state_reg;
    srf_pkg::srf_state_t  state_next;
    srf_pkg::srf_op_t     op_reg;
    logic                 word_reg;

    // Remaining count and what the final flags need to know about the start
    logic [COUNT_W-1:0]   count_reg;
    logic                 count_one_reg;
    logic                 count_zero_reg;
    logic                 sign_orig_reg;

    // Working operand and flag state
    logic [15:0]          dest_reg;
    srf_pkg::srf_flags_t  flags_reg;

    // One step of the operation: carry out above the new value
    logic [16:0]          step_out;
    logic [15:0]          dest_next;
    logic                 carry_next;
    // Request decode and phase strobes
    logic [COUNT_W-1:0]   start_count;
    logic                 take_req;
    logic                 step_en;
    logic                 last_step;
    // Overflow candidates for a count of one
    logic                 rotate_ovf;
    logic                 shift_left_ovf;

    // Top bit of the operand at the selected size
    function automatic logic top_bit(input logic [15:0] v, input logic w);
        top_bit = w ? v[15] : v[7];
    endfunction

    // Bit just below the top at the selected size
    function automatic logic next_bit(input logic [15:0] v, input logic w);
        next_bit = w ? v[14] : v[6];
    endfunction

    // Even parity of the low byte
    function automatic logic parity_even(input logic [15:0] v);
        parity_even = ~^v[7:0];
    endfunction

    // Zero test at the selected size
    function automatic logic is_zero(input logic [15:0] v, input logic w);
        is_zero = w ? (v == 16'h0000) : (v[7:0] == 8'h00);
    endfunction

    // One rotate-right step as {carry, value}; the bottom bit wraps to the top
    function automatic logic [16:0] rotate_right_step(input logic [15:0] v, input logic w);
        logic [15:0] r;
        // Byte form keeps the upper half clear
        r = w ? {v[0], v[15:1]} : {8'h00, v[0], v[7:1]};
        rotate_right_step = {v[0], r};
    endfunction

    // One left-shift step as {carry, value}; the top bit leaves, a zero enters below
    function automatic logic [16:0] shift_left_step(input logic [15:0] v, input logic w);
        logic [15:0] r;
        r = {v[14:0], 1'b0};
        // A byte operand keeps its upper half clear
        if (!w) begin
            r[15:8] = 8'h00;
        end
        shift_left_step = {top_bit(v, w), r};
    endfunction

    // One arithmetic right step as {carry, value}; the sign bit is copied downward
    function automatic logic [16:0] shift_right_arith_step(input logic [15:0] v, input logic w);
        logic [15:0] r;
        // Sign fill gives floor rounding, not truncation toward zero
        r = w ? {v[15], v[15:1]} : {8'h00, v[7], v[7:1]};
        shift_right_arith_step = {v[0], r};
    endfunction

    // Flag set after a flag load; the upper four flags pass through untouched
    function automatic srf_pkg::srf_flags_t load_from_hab(input srf_pkg::srf_flags_t f, input logic [7:0] hab);
        srf_pkg::srf_flags_t n;
        n                = f;
        n.sign_flag      = hab[srf_pkg::SRF_HAB_SIGN_BIT];
        n.zero_flag      = hab[srf_pkg::SRF_HAB_ZERO_BIT];
        n.aux_carry_flag = hab[srf_pkg::SRF_HAB_AUX_BIT];
        n.parity_flag    = hab[srf_pkg::SRF_HAB_PARITY_BIT];
        n.carry_flag     = hab[srf_pkg::SRF_HAB_CARRY_BIT];
        load_from_hab    = n;
    endfunction

    // Sign, zero and parity of a shift result; aux carry cleared as the fixed choice
    function automatic srf_pkg::srf_flags_t result_flags(input srf_pkg::srf_flags_t f, input logic [15:0] v,
                                                         input logic w);
        srf_pkg::srf_flags_t n;
        n                = f;
        n.sign_flag      = top_bit(v, w);
        n.zero_flag      = is_zero(v, w);
        n.parity_flag    = parity_even(v);
        n.aux_carry_flag = 1'b0;
        result_flags     = n;
    endfunction

    // Count source select
    assign start_count = req.count_from_reg ? count_register_low : req.imm_count[COUNT_W-1:0]; // [RQ4]

    // Phase strobes: request taken in idle, a step while count remains, last edge of the step phase
    assign take_req  = (state_reg == srf_pkg::SRF_ST_IDLE) && start;
    assign step_en   = (state_reg == srf_pkg::SRF_ST_STEP) && (count_reg != '0);    // [RQ5]
    assign last_step = (state_reg == srf_pkg::SRF_ST_STEP) && (count_reg == '0);    // [RQ5]

    // One step of the current operation
    always_comb begin
        step_out = {flags_reg.carry_flag, dest_reg};
        case (op_reg)
            srf_pkg::SRF_OP_ROT_RIGHT: begin
                // Bottom bit goes to carry and to the top
                step_out = rotate_right_step(dest_reg, word_reg);          // [RQ1] [RQ2]
            end
            srf_pkg::SRF_OP_SHIFT_LEFT, srf_pkg::SRF_OP_SHIFT_LEFT_A: begin
                // Both left shifts are the same operation
                step_out = shift_left_step(dest_reg, word_reg);            // [RQ8] [RQ9]
            end
            srf_pkg::SRF_OP_SHIFT_RIGHT_A: begin
                // Bottom bit goes to carry, sign is kept
                step_out = shift_right_arith_step(dest_reg, word_reg);     // [RQ11] [RQ12] [RQ13]
            end
            default: begin
                step_out = {flags_reg.carry_flag, dest_reg};
            end
        endcase
    end

    // Split the step output into carry and value
    assign carry_next = step_out[16];
    assign dest_next  = step_out[15:0];

    // Overflow for a count of one, from the final value; other counts leave overflow as it was
    assign rotate_ovf     = top_bit(dest_reg, word_reg) ^ next_bit(dest_reg, word_reg);   // [RQ3]
    assign shift_left_ovf = top_bit(dest_reg, word_reg) ^ sign_orig_reg;                  // [RQ10]

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            srf_pkg::SRF_ST_IDLE: begin
                // Start is ignored in any other state
                if (start) begin
                    state_next = srf_pkg::SRF_ST_STEP;
                end
            end
            srf_pkg::SRF_ST_STEP: begin
                // Zero count leaves at once: no step is taken
                if (count_reg == '0) begin                                // [RQ5]
                    state_next = srf_pkg::SRF_ST_DONE;
                end
            end
            default: begin
                // Done lasts one cycle, then back to idle
                state_next = srf_pkg::SRF_ST_IDLE;
            end
        endcase
    end

    // Sequencer state register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            // Reset returns to idle
            state_reg <= srf_pkg::SRF_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Operand capture, count-down and stepping
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            // Reset leaves an idle, empty datapath
            op_reg         <= srf_pkg::SRF_OP_NONE;
            word_reg       <= 1'b0;
            count_reg      <= COUNT_W'(srf_pkg::SRF_COUNT_RST);
            count_one_reg  <= 1'b0;
            count_zero_reg <= 1'b0;
            sign_orig_reg  <= 1'b0;
            dest_reg       <= srf_pkg::SRF_RESULT_RST;
        end else if (take_req) begin
            op_reg         <= req.op;
            word_reg       <= req.word_size;
            count_one_reg  <= (start_count == COUNT_W'(1));
            count_zero_reg <= (start_count == '0);
            sign_orig_reg  <= top_bit(req.dest, req.word_size);
            // A byte operand is held in the low half with the upper half clear
            dest_reg       <= req.word_size ? req.dest : {8'h00, req.dest[7:0]};
            // Flag load and idle ops take no steps
            if (req.op == srf_pkg::SRF_OP_FLAGS_LOAD || req.op == srf_pkg::SRF_OP_NONE) begin
                count_reg <= '0;
            end else begin
                count_reg <= start_count;                                 // [RQ4]
            end
        end else if (step_en) begin
            // One step per edge while count remains
            dest_reg  <= dest_next;                                       // [RQ5]
            count_reg <= count_reg - COUNT_W'(1);                         // [RQ5]
        end
    end

    // Flag register; a core write wins over everything else
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            // Reset clears every flag
            flags_reg <= srf_pkg::SRF_FLAGS_RST;
        end else if (flags_wr) begin
            flags_reg <= flags_wr_data;
        end else if (take_req && req.op == srf_pkg::SRF_OP_FLAGS_LOAD) begin
            // Overflow, direction, interrupt enable and trap are kept
            flags_reg <= load_from_hab(flags_reg, high_accumulator_byte);             // [RQ6] [RQ7]
        end else if (step_en) begin
            // Carry follows the bit shifted out on every step
            flags_reg.carry_flag <= carry_next;                                        // [RQ2] [RQ9] [RQ12]
        end else if (last_step) begin
            // Final flags; untouched flags hold, undefined ones take fixed values
            case (op_reg)
                srf_pkg::SRF_OP_ROT_RIGHT: begin
                    // Rotate leaves sign, zero, parity and aux alone
                    // Count other than one: overflow held as the defined choice
                    if (count_one_reg) begin
                        flags_reg.overflow_flag <= rotate_ovf;                         // [RQ3]
                    end
                end
                srf_pkg::SRF_OP_SHIFT_LEFT, srf_pkg::SRF_OP_SHIFT_LEFT_A: begin
                    // A zero count performs no step and leaves every flag as it was
                    if (!count_zero_reg) begin
                        flags_reg <= result_flags(flags_reg, dest_reg, word_reg);      // [RQ15]
                    end
                    // Assigned last so that it wins over the bundle above
                    if (count_one_reg) begin
                        flags_reg.overflow_flag <= shift_left_ovf;                     // [RQ10]
                    end
                end
                srf_pkg::SRF_OP_SHIFT_RIGHT_A: begin
                    if (count_zero_reg) begin
                        // Zero count: sign, zero and parity of the unchanged value, aux kept
                        flags_reg.sign_flag   <= top_bit(dest_reg, word_reg);
                        flags_reg.zero_flag   <= is_zero(dest_reg, word_reg);
                        flags_reg.parity_flag <= parity_even(dest_reg);
                    end else begin
                        flags_reg <= result_flags(flags_reg, dest_reg, word_reg);      // [RQ15]
                    end
                    flags_reg.overflow_flag <= 1'b0;                                   // [RQ14]
                end
                default: begin
                    flags_reg <= flags_reg;                                            // [RQ15]
                end
            endcase
        end
    end

    // Busy from the cycle after a request until idle again
    assign busy   = (state_reg != srf_pkg::SRF_ST_IDLE);
    // Done pulse in the single done state
    assign done   = (state_reg == srf_pkg::SRF_ST_DONE);
    // Result and flags straight from their registers
    assign result = dest_reg;
    assign flags  = flags_reg;

endmodule // srf_shift_rotate_flag_unit

// ==== test/srf_asserts.sv ====
`timescale 1ns/10ps
module srf_asserts #(
    parameter int COUNT_W = 8
) (
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               nrst,
    // Request
    input wire logic               start,
    input wire srf_pkg::srf_req_t  req,
    input wire logic [COUNT_W-1:0] count_register_low,
    input wire logic [7:0]         high_accumulator_byte,
    // Flags
    input wire logic               flags_wr,
    input wire srf_pkg::srf_flags_t flags,
    // Result
    input wire logic               busy,
    input wire logic               done,
    input wire logic [15:0]        result
);
    srf_pkg::srf_req_t  rq_reg;
    logic [7:0]         hab_reg;
    logic [COUNT_W-1:0] n_reg;
    wire logic          tp = rq_reg.word_size ? result[15] : result[7];
    wire logic          t2 = rq_reg.word_size ? result[14] : result[6];
    wire logic          op_rot = rq_reg.op == srf_pkg::SRF_OP_ROT_RIGHT;
    wire logic          op_right = rq_reg.op == srf_pkg::SRF_OP_SHIFT_RIGHT_A;
    wire logic          op_left = rq_reg.op inside {srf_pkg::SRF_OP_SHIFT_LEFT, srf_pkg::SRF_OP_SHIFT_LEFT_A};
    // Capture the accepted request
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rq_reg <= '0;
            hab_reg <= 8'h00;
            n_reg  <= '0;
        end else if (start && !busy) begin
            rq_reg <= req;
            hab_reg <= high_accumulator_byte;
            n_reg  <= req.count_from_reg ? count_register_low : req.imm_count;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_fl;
        start && !busy && !flags_wr && req.op == srf_pkg::SRF_OP_FLAGS_LOAD ##1 !flags_wr;
    endsequence
    property p_busy; start && !busy |=> busy; endproperty
    a_busy: assert property (p_busy) else $error("busy not raised");
    property p_pulse; done |=> !done; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_fload; s_fl |=> done && flags[4:0] == {hab_reg[7:6], hab_reg[4], hab_reg[2], hab_reg[0]}; endproperty
    a_fload: assert property (p_fload) else $error("flag load wrong");
    property p_fkeep; s_fl |=> flags[8:5] == $past(flags[8:5], 2); endproperty
    a_fkeep: assert property (p_fkeep) else $error("flag load touched others");
    property p_rorc; done && op_rot && n_reg != 0 |-> flags.carry_flag == tp; endproperty
    a_rorc: assert property (p_rorc) else $error("rotate carry wrong");
    property p_rorv; done && op_rot && n_reg == 1 |-> flags.overflow_flag == (tp ^ t2); endproperty
    a_rorv: assert property (p_rorv) else $error("rotate overflow wrong");
    property p_shlz; done && op_left && n_reg != 0 |-> !result[0]; endproperty
    a_shlz: assert property (p_shlz) else $error("left shift fill wrong");
    property p_sarv; done && op_right |-> !flags.overflow_flag; endproperty
    a_sarv: assert property (p_sarv) else $error("right shift overflow set");
endmodule // srf_asserts
bind srf_shift_rotate_flag_unit srf_asserts #(.COUNT_W(COUNT_W)) i_chk (.sys_clk(sys_clk), .nrst(nrst),
    .start(start), .req(req), .count_register_low(count_register_low), .flags_wr(flags_wr),
    .high_accumulator_byte(high_accumulator_byte), .flags(flags), .busy(busy), .done(done), .result(result));

// ==== test/tb_shift_rotate_flag_unit.sv ====
`timescale 1ns/10ps
module tb_shift_rotate_flag_unit;
    // Design signals
    logic                sys_clk = 0;
    logic                nrst = 0;
    logic                start = 0;
    logic                flags_wr = 0;
    srf_pkg::srf_req_t   req = '0;
    logic [7:0]          crl = 8'h00;
    logic [7:0]          hab = 8'h00;
    srf_pkg::srf_flags_t fwd = '0;
    srf_pkg::srf_flags_t flags;
    logic                busy;
    logic                done;
    logic [15:0]         result;
    int                  n_fail = 0;
    int                  tests_run = 0;
    int                  cyc = 0;

    srf_shift_rotate_flag_unit #(.COUNT_W(8)) i_dut (.sys_clk(sys_clk), .nrst(nrst), .start(start), .req(req),
        .count_register_low(crl), .high_accumulator_byte(hab), .flags_wr(flags_wr), .flags_wr_data(fwd),
        .flags(flags), .busy(busy), .done(done), .result(result));

    // Clock and hang guard
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end

    task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic final_report();
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Step-by-step reference of one operation: {flags, result}
    function automatic logic [24:0] m(srf_pkg::srf_op_t op, logic w, int n, logic [15:0] d,
                                      srf_pkg::srf_flags_t f, logic [7:0] hb);
        logic [15:0] r;
        int t;
        logic o;
        t = w ? 15 : 7;
        r = w ? d : {8'h00, d[7:0]};
        o = r[t];
        for (int i = 0; i < n; i++) begin
            case (op)
                srf_pkg::SRF_OP_ROT_RIGHT, srf_pkg::SRF_OP_SHIFT_RIGHT_A: begin
                    f.carry_flag = r[0];
                    r = r >> 1;
                    r[t] = (op == srf_pkg::SRF_OP_SHIFT_RIGHT_A) ? o : f.carry_flag;
                end
                default: begin
                    f.carry_flag = r[t];
                    r = w ? r << 1 : {8'h00, r[6:0], 1'b0};
                end
            endcase
        end
        if (n == 1 && op == srf_pkg::SRF_OP_ROT_RIGHT) f.overflow_flag = r[t] ^ r[t-1];
        if (n == 1 && op inside {srf_pkg::SRF_OP_SHIFT_LEFT, srf_pkg::SRF_OP_SHIFT_LEFT_A}) f.overflow_flag = r[t] ^ o;
        if (op == srf_pkg::SRF_OP_SHIFT_RIGHT_A) f.overflow_flag = 1'b0;
        if (op == srf_pkg::SRF_OP_SHIFT_RIGHT_A || (n > 0 && op != srf_pkg::SRF_OP_ROT_RIGHT)) begin
            f.sign_flag = r[t];
            f.zero_flag = (r == 16'h0000);
            f.parity_flag = ~^r[7:0];
            if (n > 0) f.aux_carry_flag = 1'b0;
        end
        if (op == srf_pkg::SRF_OP_FLAGS_LOAD) f[4:0] = {hb[7:6], hb[4], hb[2], hb[0]};
        return {f, r};
    endfunction

    // Preset flags, issue one request, optionally retry start while busy, then judge
    task automatic run(srf_pkg::srf_op_t op, logic w, logic fr, logic [7:0] n, logic [15:0] d,
                       logic [7:0] hb, logic [8:0] fp, logic dup = 0);
        int k;
        int nn;
        logic [24:0] e;
        nn = (op == srf_pkg::SRF_OP_FLAGS_LOAD || op == srf_pkg::SRF_OP_NONE) ? 0 : int'(n);
        e = m(op, w, nn, d, fp, hb);
        @(negedge sys_clk);
        flags_wr = 1;
        fwd = fp;
        @(negedge sys_clk);
        flags_wr = 0;
        start = 1;
        req = '{op, w, fr, fr ? ~n : n, d};
        crl = fr ? n : ~n;
        hab = hb;
        @(negedge sys_clk);
        k = 1;
        if (dup) begin
            req.op = srf_pkg::SRF_OP_SHIFT_LEFT_A;
            req.dest = ~d;
            @(negedge sys_clk);
            k = 2;
        end
        start = 0;
        while (done !== 1'b1 && k < 400) begin
            @(negedge sys_clk);
            k++;
        end
        chk("latency", 16'(k), 16'(nn + 2));
        chk("result", result, e[15:0]);
        chk("flags", 16'(flags), 16'(e[24:16]));
    endtask

    task automatic t_ror();
        run(srf_pkg::SRF_OP_ROT_RIGHT, 1, 0, 1, 16'h0001, 0, 9'h000);
        run(srf_pkg::SRF_OP_ROT_RIGHT, 0, 1, 3, 16'h1281, 0, 9'h1ff);
        run(srf_pkg::SRF_OP_ROT_RIGHT, 1, 0, 0, 16'h1234, 0, 9'h155);
    endtask

    task automatic t_shift();
        for (int i = 0; i < 2; i++) begin
            run(i ? srf_pkg::SRF_OP_SHIFT_LEFT_A : srf_pkg::SRF_OP_SHIFT_LEFT, 1, 0, 1, 16'h4001, 0, 9'h010);
            run(i ? srf_pkg::SRF_OP_SHIFT_LEFT_A : srf_pkg::SRF_OP_SHIFT_LEFT, 0, 1, 2, 16'hffc3, 0, 9'h1ff);
        end
        run(srf_pkg::SRF_OP_SHIFT_LEFT, 1, 0, 17, 16'hffff, 0, 9'h000);
        run(srf_pkg::SRF_OP_SHIFT_LEFT, 0, 0, 0, 16'h0080, 0, 9'h1ff);
    endtask

    task automatic t_sar();
        run(srf_pkg::SRF_OP_SHIFT_RIGHT_A, 1, 0, 1, 16'hfffb, 0, 9'h1ff);
        run(srf_pkg::SRF_OP_SHIFT_RIGHT_A, 0, 1, 3, 16'h0085, 0, 9'h000);
        run(srf_pkg::SRF_OP_SHIFT_RIGHT_A, 1, 1, 20, 16'h8000, 0, 9'h100);
        run(srf_pkg::SRF_OP_SHIFT_RIGHT_A, 1, 0, 0, 16'h4000, 0, 9'h100);
        run(srf_pkg::SRF_OP_SHIFT_RIGHT_A, 0, 0, 0, 16'h0080, 0, 9'h004);
    endtask

    task automatic t_fload();
        run(srf_pkg::SRF_OP_FLAGS_LOAD, 0, 0, 0, 16'h0000, 8'hd5, 9'h1e0);
        run(srf_pkg::SRF_OP_FLAGS_LOAD, 0, 0, 0, 16'h0000, 8'h2a, 9'h01f);
        run(srf_pkg::SRF_OP_NONE, 1, 0, 5, 16'h5a5a, 8'hff, 9'h0aa);
    endtask

    // Main sequence
    initial begin
        repeat (12) @(negedge sys_clk);
        chk("reset state", {5'h00, busy, done, flags}, 16'h0000);
        chk("reset result", result, 16'h0000);
        nrst = 1;
        t_ror();
        t_shift();
        t_sar();
        t_fload();
        run(srf_pkg::SRF_OP_ROT_RIGHT, 1, 0, 4, 16'h00f0, 0, 9'h000, 1);
        final_report();
    end
endmodule // tb_shift_rotate_flag_unit
